// *** src/lmodf_top.v ***
// Purpose: Mode-dependent opcode decode filter with an APB register file.
// Assumes: Fetch delivers prefix and opcode bytes, plus the ModRM byte only
//   for ff, 63 and 0f ae; mode and privilege inputs share clk.
// Notes: Other opcodes are emitted at once with their byte for the pipeline.
//
// How it works
// - Bytes 40-4f are extension prefix in 64-bit mode.
// - ff /0 and ff /1 still increment and decrement.
// - Byte 63 is sign-extend move, else privilege adjust.
// - Move reads 32 bits; prefix extends to 64.
// - Invalid opcodes raise fault instead of executing.
// - Decimal and ASCII adjust opcodes invalid in 64-bit.
// - Opcodes 62 and ce invalid in 64-bit.
// - Absolute far call and jump invalid in 64-bit.
// - Far pointer loads c5, c4 invalid in 64-bit.
// - Segment push and pop bytes invalid in 64-bit.
// - Push-all and pop-all invalid in 64-bit.
// - Opcodes 82 and d6 invalid in 64-bit.
// - Fast syscall entry and return invalid in long mode.
// - Save/restore with 32-bit size uses legacy layout.
// - Save/restore with 64-bit size uses expanded layout.
// - Fast save at level 0 in 64-bit skips vectors.
// - Environment and control register always transferred.
// - Fast save ignored outside 64-bit or above level 0.
// - Feature word reports fast save support bit.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "lmodf_consts.vh"

module lmodf_top #(
	parameter FAST_SAVE_SUPPORTED = 1
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire long_mode,
	input wire cs_long,
	input wire [1:0] current_privilege_level,
	input wire in_valid,
	input wire [7:0] in_byte,
	output reg in_ready_q,
	output reg op_valid_q,
	input wire op_ready,
	output reg [`LMODF_CLS_W-1:0] op_cls_q,
	output reg [7:0] op_byte_q,
	output reg [7:0] op_modrm_q,
	output reg [3:0] op_prefix_q,
	output reg op_prefix_seen_q,
	output reg op_fault_q,
	output reg op_src32_q,
	output reg op_sext64_q,
	output reg op_fmt64_q,
	output reg op_skip_vec_q,
	output reg op_xfer_env_q,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`LMODF_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q
);

	reg [1:0] state_q;
	reg [7:0] opc_q;
	reg two_byte_q;
	reg [3:0] prefix_q;
	reg prefix_seen_q;
	reg fast_save_en_q;
	reg [`LMODF_FAULT_CNT_W-1:0] fault_cnt_q;
	reg [8:0] last_fault_q;
	wire mode64;
	wire take;
	wire drain;
	wire cls_invalid;
	wire cls_modrm;
	wire [`LMODF_CLS_W-1:0] cls_code;
	wire [7:0] cls_opc;
	wire cls_two;
	wire fast_skip;
	wire apb_access;
	wire [31:0] rd_word;
	wire rd_hit;

	// ModRM reg field, the group opcode extension.
	function [2:0] modrm_ext;
		input [7:0] modrm;
		begin
			modrm_ext = modrm[5:3];
		end
	endfunction

	// Matches a register offset on a word-aligned address.
	function addr_is;
		input [`LMODF_ADDR_W-1:0] addr;
		input [`LMODF_ADDR_W-1:0] off;
		begin
			addr_is = (addr == off);
		end
	endfunction

	assign mode64 = long_mode & cs_long;
	assign take = ce & in_valid & in_ready_q;
	assign drain = ce & op_valid_q & op_ready;

	// In the escape state the byte is classified as a two-byte opcode.
	assign cls_opc = in_byte;
	assign cls_two = (state_q == `LMODF_S_0F);

	lmodf_classify u_classify (
		.opc(cls_opc),
		.two_byte(cls_two),
		.long_mode(long_mode),
		.cs_long(cs_long),
		.invalid(cls_invalid),
		.needs_modrm(cls_modrm),
		.cls(cls_code)
	);

	// Fast save needs all three: enable, 64-bit code and level 0.
	assign fast_skip = fast_save_en_q & mode64 &
		(current_privilege_level == 2'd0);

	// Byte intake and decode state machine.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= `LMODF_S_OPC;
			opc_q <= 8'h00;
			two_byte_q <= 1'b0;
			prefix_q <= 4'h0;
			prefix_seen_q <= 1'b0;
			in_ready_q <= 1'b0;
			op_valid_q <= 1'b0;
			op_cls_q <= `LMODF_CLS_OTHER;
			op_byte_q <= 8'h00;
			op_modrm_q <= 8'h00;
			op_prefix_q <= 4'h0;
			op_prefix_seen_q <= 1'b0;
			op_fault_q <= 1'b0;
			op_src32_q <= 1'b0;
			op_sext64_q <= 1'b0;
			op_fmt64_q <= 1'b0;
			op_skip_vec_q <= 1'b0;
			op_xfer_env_q <= 1'b0;
			fault_cnt_q <= 16'h0000;
			last_fault_q <= 9'h000;
		end else if (ce) begin
			if (!op_valid_q && !in_ready_q) begin
				in_ready_q <= 1'b1;
			end
			if (drain) begin
				op_valid_q <= 1'b0;
				in_ready_q <= 1'b1;
			end
			if (take) begin
				case (state_q)
					`LMODF_S_OPC: begin
						opc_q <= in_byte;
						two_byte_q <= 1'b0;
						if (mode64 && in_byte[7:4] == `LMODF_PREFIX_HI) begin
							// A later prefix replaces an earlier one.
							prefix_q <= in_byte[3:0];
							prefix_seen_q <= 1'b1;
						end else if (in_byte == `LMODF_OPC_ESC) begin
							state_q <= `LMODF_S_0F;
						end else if (cls_modrm) begin
							state_q <= `LMODF_S_MODRM;
						end else begin
							in_ready_q <= 1'b0;
							op_valid_q <= 1'b1;
							op_cls_q <= cls_code;
							op_byte_q <= in_byte;
							op_modrm_q <= 8'h00;
							op_prefix_q <= prefix_q;
							op_prefix_seen_q <= prefix_seen_q;
							op_fault_q <= cls_invalid;
							op_src32_q <= 1'b0;
							op_sext64_q <= 1'b0;
							op_fmt64_q <= 1'b0;
							op_skip_vec_q <= 1'b0;
							op_xfer_env_q <= 1'b0;
							prefix_q <= 4'h0;
							prefix_seen_q <= 1'b0;
							if (cls_invalid) begin
								fault_cnt_q <= fault_cnt_q + 16'h0001;
								last_fault_q <= {1'b0, in_byte};
							end
						end
					end
					`LMODF_S_0F: begin
						opc_q <= in_byte;
						two_byte_q <= 1'b1;
						if (cls_modrm) begin
							state_q <= `LMODF_S_MODRM;
						end else begin
							state_q <= `LMODF_S_OPC;
							in_ready_q <= 1'b0;
							op_valid_q <= 1'b1;
							op_cls_q <= cls_code;
							op_byte_q <= in_byte;
							op_modrm_q <= 8'h00;
							op_prefix_q <= prefix_q;
							op_prefix_seen_q <= prefix_seen_q;
							op_fault_q <= cls_invalid;
							op_src32_q <= 1'b0;
							op_sext64_q <= 1'b0;
							op_fmt64_q <= 1'b0;
							op_skip_vec_q <= 1'b0;
							op_xfer_env_q <= 1'b0;
							prefix_q <= 4'h0;
							prefix_seen_q <= 1'b0;
							if (cls_invalid) begin
								fault_cnt_q <= fault_cnt_q + 16'h0001;
								last_fault_q <= {1'b1, in_byte};
							end
						end
					end
					`LMODF_S_MODRM: begin
						state_q <= `LMODF_S_OPC;
						in_ready_q <= 1'b0;
						op_valid_q <= 1'b1;
						op_byte_q <= opc_q;
						op_modrm_q <= in_byte;
						op_prefix_q <= prefix_q;
						op_prefix_seen_q <= prefix_seen_q;
						op_fault_q <= 1'b0;
						op_src32_q <= 1'b0;
						op_sext64_q <= 1'b0;
						op_fmt64_q <= 1'b0;
						op_skip_vec_q <= 1'b0;
						op_xfer_env_q <= 1'b0;
						prefix_q <= 4'h0;
						prefix_seen_q <= 1'b0;
						if (two_byte_q) begin
							case (modrm_ext(in_byte))
								`LMODF_EXT_SAVE: begin
									op_cls_q <= `LMODF_CLS_SAVE;
								end
								`LMODF_EXT_RESTORE: begin
									op_cls_q <= `LMODF_CLS_RESTORE;
								end
								default: begin
									op_cls_q <= `LMODF_CLS_0F_OTHER;
								end
							endcase
							if (modrm_ext(in_byte) == `LMODF_EXT_SAVE ||
								modrm_ext(in_byte) == `LMODF_EXT_RESTORE) begin
								// Operand size 64 needs the W bit of a prefix.
								op_fmt64_q <= mode64 & prefix_q[3];
								op_skip_vec_q <= fast_skip;
								op_xfer_env_q <= 1'b1;
							end
						end else if (opc_q == `LMODF_OPC_GRP5) begin
							case (modrm_ext(in_byte))
								`LMODF_EXT_INC: begin
									op_cls_q <= `LMODF_CLS_INC;
								end
								`LMODF_EXT_SUB_ONE: begin
									op_cls_q <= `LMODF_CLS_SUB_ONE;
								end
								default: begin
									op_cls_q <= `LMODF_CLS_FF_OTHER;
								end
							endcase
						end else if (mode64) begin
							op_cls_q <= `LMODF_CLS_SXD;
							op_src32_q <= 1'b1;
							op_sext64_q <= prefix_seen_q;
						end else begin
							op_cls_q <= `LMODF_CLS_PRIV_ADJ;
						end
					end
					default: begin
						state_q <= `LMODF_S_OPC;
					end
				endcase
			end
		end
	end

	// APB slave: one wait state, writes land on the completing edge.
	assign apb_access = psel & penable;

	assign rd_hit = addr_is(paddr, `LMODF_OFF_CTRL) |
		addr_is(paddr, `LMODF_OFF_FEATURE) |
		addr_is(paddr, `LMODF_OFF_FAULT_CNT) |
		addr_is(paddr, `LMODF_OFF_LAST_FAULT);

	assign rd_word = addr_is(paddr, `LMODF_OFF_CTRL) ?
		{31'h00000000, fast_save_en_q} :
		addr_is(paddr, `LMODF_OFF_FEATURE) ?
		({31'h00000000, (FAST_SAVE_SUPPORTED != 0)} <<
		`LMODF_FEAT_FAST_SAVE_BIT) :
		addr_is(paddr, `LMODF_OFF_FAULT_CNT) ?
		{16'h0000, fault_cnt_q} :
		addr_is(paddr, `LMODF_OFF_LAST_FAULT) ?
		{23'h000000, last_fault_q} :
		32'h00000000;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			fast_save_en_q <= `LMODF_CTRL_RESET;
		end else if (ce) begin
			if (apb_access && !pready_q) begin
				pready_q <= 1'b1;
				pslverr_q <= ~rd_hit;
				prdata_q <= pwrite ? 32'h00000000 : rd_word;
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
			// The enable sticks at zero when the feature is absent.
			if (apb_access && pready_q && pwrite &&
				addr_is(paddr, `LMODF_OFF_CTRL)) begin
				fast_save_en_q <= pwdata[`LMODF_CTRL_FAST_SAVE_BIT] &
					(FAST_SAVE_SUPPORTED != 0);
			end
		end
	end

endmodule // lmodf_top

// *** src/lmodf_consts.vh ***
// Purpose: Constants shared by the long mode opcode decode filter.
// Assumes: Included by bare name from every design file of the block.
// Notes: Definitions only.
`ifndef LMODF_CONSTS_VH
`define LMODF_CONSTS_VH

// Decoder states.
`define LMODF_S_OPC 2'd0
`define LMODF_S_0F 2'd1
`define LMODF_S_MODRM 2'd2

// Decoded operation classes.
`define LMODF_CLS_W 4
`define LMODF_CLS_OTHER 4'h0
`define LMODF_CLS_INCDEC_SHORT 4'h1
`define LMODF_CLS_INC 4'h2
`define LMODF_CLS_SUB_ONE 4'h3
`define LMODF_CLS_FF_OTHER 4'h4
`define LMODF_CLS_SXD 4'h5
`define LMODF_CLS_PRIV_ADJ 4'h6
`define LMODF_CLS_SAVE 4'h7
`define LMODF_CLS_RESTORE 4'h8
`define LMODF_CLS_FAULT 4'h9
`define LMODF_CLS_0F_OTHER 4'ha

// Opcode bytes with special handling.
`define LMODF_OPC_ESC 8'h0f
`define LMODF_OPC_GRP5 8'hff
`define LMODF_OPC_SXD 8'h63
`define LMODF_OPC_GRP15 8'hae
`define LMODF_OPC_FAST_ENTRY 8'h34
`define LMODF_OPC_FAST_RETURN 8'h35
`define LMODF_PREFIX_HI 4'h4

// ModRM reg field values.
`define LMODF_EXT_INC 3'd0
`define LMODF_EXT_SUB_ONE 3'd1
`define LMODF_EXT_SAVE 3'd0
`define LMODF_EXT_RESTORE 3'd1

// Register offsets (byte addresses) and fields.
`define LMODF_ADDR_W 12
`define LMODF_OFF_CTRL 12'h000
`define LMODF_OFF_FEATURE 12'h004
`define LMODF_OFF_FAULT_CNT 12'h008
`define LMODF_OFF_LAST_FAULT 12'h00c
`define LMODF_CTRL_FAST_SAVE_BIT 0
`define LMODF_CTRL_RESET 1'b0
`define LMODF_FEAT_FAST_SAVE_BIT 0
`define LMODF_FAULT_CNT_W 16

`endif

// *** src/lmodf_classify.v ***
// Purpose: First-level opcode classification by operating mode.
// Assumes: Combinational; the caller registers the results.
// Notes: Covers one-byte opcodes and the byte after the 0f escape.
`timescale 1ns/100ps
`include "lmodf_consts.vh"

module lmodf_classify (
	input wire [7:0] opc,
	input wire two_byte,
	input wire long_mode,
	input wire cs_long,
	output reg invalid,
	output reg needs_modrm,
	output reg [`LMODF_CLS_W-1:0] cls
);

	wire mode64;

	assign mode64 = long_mode & cs_long;

	always @* begin
		invalid = 1'b0;
		needs_modrm = 1'b0;
		cls = `LMODF_CLS_OTHER;
		if (two_byte) begin
			cls = `LMODF_CLS_0F_OTHER;
			case (opc)
				`LMODF_OPC_FAST_ENTRY, `LMODF_OPC_FAST_RETURN: begin
					invalid = long_mode;
				end
				`LMODF_OPC_GRP15: begin
					needs_modrm = 1'b1;
				end
				default: begin
					cls = `LMODF_CLS_0F_OTHER;
				end
			endcase
		end else begin
			case (opc)
				8'h37, 8'hd5, 8'hd4, 8'h3f, 8'h27, 8'h2f: begin
					invalid = mode64;
				end
				8'h62, 8'hce: begin
					invalid = mode64;
				end
				8'h9a, 8'hea: begin
					invalid = mode64;
				end
				8'hc5, 8'hc4: begin
					invalid = mode64;
				end
				8'h1f, 8'h07, 8'h17, 8'h0e, 8'h1e, 8'h06, 8'h16: begin
					invalid = mode64;
				end
				8'h60, 8'h61: begin
					invalid = mode64;
				end
				8'h82, 8'hd6: begin
					invalid = mode64;
				end
				`LMODF_OPC_SXD, `LMODF_OPC_GRP5: begin
					needs_modrm = 1'b1;
				end
				default: begin
					if (opc[7:4] == `LMODF_PREFIX_HI && !mode64) begin
						cls = `LMODF_CLS_INCDEC_SHORT;
					end
				end
			endcase
		end
		if (invalid) begin
			cls = `LMODF_CLS_FAULT;
		end
	end

endmodule // lmodf_classify

// *** bench/lmodf_props.sv ***
// Purpose: Port checker for the opcode decode filter.
// Assumes: Bound to lmodf_top; mode inputs change only between ops.
// Notes: Mode is sampled one edge before an op appears.
`timescale 1ns/100ps
`include "lmodf_consts.vh"
module lmodf_props (
	input wire clk,
	input wire rst,
	input wire long_mode,
	input wire cs_long,
	input wire [1:0] current_privilege_level,
	input wire op_valid_q,
	input wire [`LMODF_CLS_W-1:0] op_cls_q,
	input wire [7:0] op_byte_q,
	input wire op_fault_q,
	input wire op_src32_q,
	input wire op_fmt64_q,
	input wire op_skip_vec_q,
	input wire op_xfer_env_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_new;
		$rose(op_valid_q);
	endsequence
	sequence s_was64;
		$past(long_mode && cs_long);
	endsequence
	chk_fault_class: assert property (op_valid_q |->
		op_fault_q == (op_cls_q == `LMODF_CLS_FAULT))
		else $error("fault flag and class disagree");
	chk_bad_op:
	assert property ((s_new ##0 s_was64 ##0 op_byte_q inside {8'h37, 8'hd5,
		8'hd4, 8'h3f, 8'h27, 8'h2f, 8'h62, 8'hce, 8'h9a, 8'hea, 8'hc5, 8'hc4,
		8'h1f, 8'h07, 8'h17, 8'h0e, 8'h1e, 8'h06, 8'h16, 8'h60, 8'h61, 8'h82,
		8'hd6} && op_cls_q != `LMODF_CLS_0F_OTHER) |-> op_fault_q)
		else $error("invalid opcode not faulted");
	chk_sys_fault: assert property ((s_new ##0 $past(long_mode)
		##0 op_byte_q inside {8'h34, 8'h35} && op_cls_q != `LMODF_CLS_OTHER)
		|-> op_fault_q) else $error("fast syscall not faulted");
	chk_short_legacy: assert property ((s_new ##0
		op_cls_q == `LMODF_CLS_INCDEC_SHORT) |-> !$past(long_mode && cs_long)
		&& op_byte_q[7:4] == `LMODF_PREFIX_HI)
		else $error("short form decoded in 64-bit mode");
	chk_sxd_mode: assert property ((s_new ##0
		op_cls_q == `LMODF_CLS_SXD) |-> s_was64 ##0 op_src32_q)
		else $error("sign-extend move outside 64-bit mode");
	chk_env_xfer: assert property (op_valid_q &&
		op_cls_q inside {`LMODF_CLS_SAVE, `LMODF_CLS_RESTORE} |-> op_xfer_env_q)
		else $error("environment not transferred");
	chk_skip_mode: assert property ((s_new ##0 op_skip_vec_q) |->
		$past(long_mode && cs_long && current_privilege_level == 2'b00))
		else $error("vector skip outside 64-bit level 0");
	chk_fmt_save: assert property (op_valid_q && op_fmt64_q |->
		op_cls_q inside {`LMODF_CLS_SAVE, `LMODF_CLS_RESTORE})
		else $error("expanded layout on other op");
endmodule // lmodf_props
bind lmodf_top lmodf_props lmodf_props_i (.clk, .rst, .long_mode, .cs_long,
	.current_privilege_level, .op_valid_q, .op_cls_q, .op_byte_q,
	.op_fault_q, .op_src32_q,
	.op_fmt64_q, .op_skip_vec_q, .op_xfer_env_q);

// *** bench/lmodf_sink.sv ***
// Purpose: Execution pipeline stand-in that takes decoded ops.
// Assumes: Shares clk and rst with the decoder.
// Notes: Ready lags one cycle, so every op is held at least two cycles.
`timescale 1ns/100ps
module lmodf_sink (
	input wire clk,
	input wire rst,
	input wire stall,
	input wire op_valid_q,
	output logic op_ready
);
	always @(posedge clk or posedge rst) begin
		if (rst)
			op_ready <= 1'b0;
		else
			op_ready <= op_valid_q && !stall;
	end
endmodule // lmodf_sink

// *** bench/lmodf_bench.sv ***
// Purpose: Self-checking bench for the opcode decode filter.
// Assumes: Clock enable high except in its own scenario.
// Notes: Byte feed and APB master are bench tasks.
`timescale 1ns/100ps
`include "lmodf_consts.vh"
module lmodf_bench;
	logic clk, rst, ce, long_mode, cs_long, in_valid, stall, in_ready_q;
	logic op_valid_q, op_ready, op_prefix_seen_q, op_fault_q, op_src32_q;
	logic op_sext64_q, op_fmt64_q, op_skip_vec_q, op_xfer_env_q;
	logic psel, penable, pwrite, pready_q, pslverr_q, er;
	logic [1:0] current_privilege_level;
	logic [3:0] op_prefix_q, op_cls_q;
	logic [7:0] in_byte, op_byte_q, op_modrm_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q, rd, c0;
	logic [7:0] q[$];
	int fails, n_tests;
	lmodf_top lmodf_top_i (.clk, .rst, .ce, .long_mode, .cs_long,
		.current_privilege_level, .in_valid, .in_byte, .in_ready_q,
		.op_valid_q, .op_ready, .op_cls_q, .op_byte_q, .op_modrm_q,
		.op_prefix_q, .op_prefix_seen_q, .op_fault_q, .op_src32_q,
		.op_sext64_q, .op_fmt64_q, .op_skip_vec_q, .op_xfer_env_q, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q,
		.pslverr_q);
	lmodf_sink lmodf_sink_i (.clk, .rst, .stall, .op_valid_q, .op_ready);
	task automatic chk(input string n, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready_q !== 1);
		rd = prdata_q;
		er = pslverr_q;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic mode(input logic l, c, input logic [1:0] p);
		@(posedge clk);
		long_mode <= l;
		cs_long <= c;
		current_privilege_level <= p;
	endtask
	// Feeds the queued bytes, then waits for the op; the sink drains it.
	task automatic feed(input logic [3:0] ec, input logic ef);
		@(posedge clk);
		foreach (q[i]) begin
			in_valid <= 1;
			in_byte <= q[i];
			do @(posedge clk); while (in_ready_q !== 1);
		end
		in_valid <= 0;
		do @(negedge clk); while (op_valid_q !== 1);
		chk("cls", op_cls_q, ec);
		chk("fault", op_fault_q, ef);
	endtask
	task automatic t_bad();
		logic [7:0] b[23] = '{8'h37, 8'hd5, 8'hd4, 8'h3f, 8'h27, 8'h2f, 8'h62,
			8'hce, 8'h9a, 8'hea, 8'hc5, 8'hc4, 8'h1f, 8'h07, 8'h17, 8'h0e,
			8'h1e, 8'h06, 8'h16, 8'h60, 8'h61, 8'h82, 8'hd6};
		apb(0, `LMODF_OFF_FAULT_CNT, 0);
		c0 = rd;
		for (int m = 0; m < 2; m++) begin
			mode(1, m == 0, 0);
			foreach (b[i]) begin
				q = '{b[i]};
				feed(m ? `LMODF_CLS_OTHER : `LMODF_CLS_FAULT, !m);
			end
		end
		apb(0, `LMODF_OFF_FAULT_CNT, 0);
		chk("count", rd - c0, 23);
		apb(0, 12'h010, 0);
		chk("unmapped", er, 1);
		apb(0, `LMODF_OFF_FEATURE, 0);
		chk("feature", rd[0], 1);
	endtask
	// Bytes offered while the clock enable is low must not be taken.
	task automatic t_ce();
		mode(1, 1, 0);
		@(posedge clk);
		ce <= 0;
		in_valid <= 1;
		in_byte <= 8'h37;
		repeat (3) @(posedge clk);
		chk("frozen", {in_ready_q, op_valid_q}, 2'b10);
		in_valid <= 0;
		ce <= 1;
		q = '{8'h37};
		feed(`LMODF_CLS_FAULT, 1);
	endtask
	task automatic t_rex();
		mode(1, 1, 0);
		q = '{8'h48, 8'h63, 8'hc0};
		feed(`LMODF_CLS_SXD, 0);
		chk("pfx", {op_prefix_seen_q, op_prefix_q}, 5'h18);
		chk("sx", {op_src32_q, op_sext64_q}, 2'b11);
		q = '{8'h63, 8'hc0};
		feed(`LMODF_CLS_SXD, 0);
		chk("sx", {op_src32_q, op_sext64_q}, 2'b10);
		q = '{8'hff, 8'hc0};
		feed(`LMODF_CLS_INC, 0);
		q = '{8'h4f, 8'hff, 8'hc8};
		feed(`LMODF_CLS_SUB_ONE, 0);
		chk("pfx", {op_prefix_seen_q, op_prefix_q}, 5'h1f);
		chk("opc", {op_byte_q, op_modrm_q}, 16'hffc8);
		mode(1, 0, 0);
		q = '{8'h4f};
		feed(`LMODF_CLS_INCDEC_SHORT, 0);
		chk("short", {op_prefix_seen_q, op_byte_q}, 9'h04f);
		q = '{8'h63, 8'hc0};
		feed(`LMODF_CLS_PRIV_ADJ, 0);
	endtask
	task automatic t_sys();
		for (int i = 0; i < 6; i++) begin
			mode(i < 4, i < 2, 0);
			q = '{8'h0f, 8'h34 + i[0]};
			feed(i < 4 ? `LMODF_CLS_FAULT : `LMODF_CLS_0F_OTHER, i < 4);
		end
	endtask
	task automatic sv(input logic [1:0] p, input logic c, input logic [2:0] e);
		mode(1, c, p);
		q = '{8'h0f, 8'hae, 8'h00};
		feed(`LMODF_CLS_SAVE, 0);
		chk("layout", {op_fmt64_q, op_skip_vec_q, op_xfer_env_q}, e);
	endtask
	task automatic t_save();
		apb(1, `LMODF_OFF_CTRL, 1);
		apb(0, `LMODF_OFF_CTRL, 0);
		chk("ctrl", rd, 1);
		stall <= 1;
		sv(0, 1, 3'b011);
		repeat (4) @(posedge clk);
		chk("held", {op_valid_q, op_cls_q}, 5'h17);
		stall <= 0;
		q = '{8'h48, 8'h0f, 8'hae, 8'h08};
		feed(`LMODF_CLS_RESTORE, 0);
		chk("layout", {op_fmt64_q, op_skip_vec_q, op_xfer_env_q}, 3'b111);
		sv(3, 1, 3'b001);
		sv(0, 0, 3'b001);
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst, long_mode, cs_long, current_privilege_level, in_valid, in_byte,
			stall} = 15'h4000;
		ce = 1;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		repeat (8) @(posedge clk);
		rst <= 0;
		apb(0, `LMODF_OFF_CTRL, 0);
		chk("ctrl", rd, 0);
		t_bad();
		t_ce();
		t_rex();
		t_sys();
		t_save();
		end_sim();
	end
	// The run needs well under a thousand cycles; the 25000-cycle limit leaves a wide margin.
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule // lmodf_bench
